// ---- rtl/iwmc_map.svh ----
// Behaviour
// - sample select pin at power-up: 0 implant
// - implant sleeps after power-up until wake
// - base powers up with MAC idle
// - host holds wake pin high over 1.5ms
// - direct wake enters idle, flag set one
// - flag one idles, zero sends wake responses
// - host sets mode/channel before clearing flag
// - flag write zero starts 400-MHz responses
// - base host programs link registers first
// - base host does CCA before wake
// - wake start drives OOK and 400-MHz radio
// - sleeping receiver strobed at programmable interval
// - strobes from oscillator, pin, or both
// - after 2.45-GHz wake send responses, listen
// - randomize interval between response packets
// - base host opens session by register
// - pin wake base monitors chosen channel
// - emergency wake needs no CCA
// - standby sleep leaves only on pin strobe; code also leaves SLEEP on oscillator strobe or direct wake
// - internal 25-kHz strobe generator replaces pin
`ifndef IWMC_MAP_SVH
`define IWMC_MAP_SVH
`define IWMC_CLK_HZ 200000000
`define IWMC_WAKE_MIN_US 1500
`define IWMC_WAKE_MIN_CYC ((`IWMC_CLK_HZ / 1000000) * `IWMC_WAKE_MIN_US)
`define IWMC_STROSC_HZ 25000
`define IWMC_STROSC_DIV (`IWMC_CLK_HZ / `IWMC_STROSC_HZ)
`define IWMC_SNIFF_US 200
`define IWMC_SNIFF_CYC ((`IWMC_CLK_HZ / 1000000) * `IWMC_SNIFF_US)
`define IWMC_LFSR_SEED 16'hACE1
`define IWMC_OOK_PATTERN 16'hA5C3
`endif

// ---- rtl/iwmc_pkg.sv ----
package iwmc_pkg;
  typedef enum logic [4:0] {
    IWMC_OFF   = 5'h01,
    IWMC_SLEEP = 5'h02,
    IWMC_SNIFF = 5'h04,
    IWMC_IDLE  = 5'h08,
    IWMC_RF    = 5'h10
  } iwmc_state_t;
endpackage : iwmc_pkg

// ---- rtl/iwmc_link_if.sv ----
`timescale 1ns/1ps
interface iwmc_link_if;
  logic implant_base_select;
  logic wake_pin;
  logic flag_wr;
  logic flag_val;
  logic comm_wr;
  logic comm_wake;
  logic comm_session;
  logic rx_245_msg;
  logic [1:0] strobe_src;
  logic [15:0] strobe_div;
  logic [4:0] state;
  logic flag;
  logic tx_400;
  logic rx_400;
  logic ook;
  logic resp_pulse;
  logic sniff_on;
  modport dev (input implant_base_select, wake_pin, flag_wr, flag_val, comm_wr, comm_wake, comm_session,
    rx_245_msg, strobe_src, strobe_div, output state, flag, tx_400, rx_400, ook, resp_pulse, sniff_on);
  modport host (output implant_base_select, wake_pin, flag_wr, flag_val, comm_wr, comm_wake, comm_session,
    strobe_src, strobe_div, input state, flag, tx_400, rx_400, ook, resp_pulse, sniff_on, rx_245_msg);
endinterface : iwmc_link_if

// ---- rtl/iwmc_dev.sv ----
`timescale 1ns/1ps
`include "iwmc_map.svh"
module iwmc_dev
  import iwmc_pkg::*;
#(
  parameter int WAKE_MIN_CYC = `IWMC_WAKE_MIN_CYC,
  parameter int SNIFF_CYC = `IWMC_SNIFF_CYC,
  parameter int STROSC_DIV = `IWMC_STROSC_DIV
) (
  // system
  input wire logic clock,
  input wire logic resetn,
  // link
  iwmc_link_if.dev lnk
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] ibs_sync_r;
  logic [2:0] wake_sync_r;
  logic wake_lvl_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ibs_sync_r <= 3'h0;
      wake_sync_r <= 3'h0;
    end else begin
      ibs_sync_r <= {ibs_sync_r[1:0], lnk.implant_base_select};
      wake_sync_r <= {wake_sync_r[1:0], lnk.wake_pin};
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wake_lvl_r <= 1'b0;
    end else if (wake_sync_r[1] == wake_sync_r[2]) begin
      wake_lvl_r <= wake_sync_r[2];
    end
  end
  wire wake_rise = wake_lvl_r == 1'b0 && wake_sync_r[1] && wake_sync_r[2];
  wire wake_fall = wake_lvl_r && !wake_sync_r[1] && !wake_sync_r[2];
  // ----------------------------------------
  // mode capture after reset release
  // ----------------------------------------
  logic base_mode_r;
  logic [2:0] settle_r;
  // strap reaches the third stage only after three edges; last capture on the fourth
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      settle_r <= 3'h0;
      base_mode_r <= 1'b0;
    end else if (settle_r != 3'h4) begin
      settle_r <= settle_r + 3'h1;
      base_mode_r <= ibs_sync_r[2];
    end
  end
  wire mode_ready = settle_r == 3'h4;
  // ----------------------------------------
  // wake pin width measurement
  // ----------------------------------------
  logic [31:0] high_cnt_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      high_cnt_r <= 32'h0;
    end else if (!wake_lvl_r) begin
      high_cnt_r <= 32'h0;
    end else if (high_cnt_r <= 32'(WAKE_MIN_CYC)) begin
      high_cnt_r <= high_cnt_r + 32'h1;
    end
  end
  wire direct_wake = wake_fall && high_cnt_r > 32'(WAKE_MIN_CYC);
  // ----------------------------------------
  // strobe generation
  // ----------------------------------------
  logic [15:0] osc_cnt_r;
  logic [15:0] ivl_cnt_r;
  logic osc_tick;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      osc_cnt_r <= 16'h0;
    end else if (!lnk.strobe_src[0] || osc_cnt_r == 16'(STROSC_DIV - 1)) begin
      osc_cnt_r <= 16'h0;
    end else begin
      osc_cnt_r <= osc_cnt_r + 16'h1;
    end
  end
  assign osc_tick = lnk.strobe_src[0] && osc_cnt_r == 16'(STROSC_DIV - 1);
  logic osc_strobe;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ivl_cnt_r <= 16'h0;
    end else if (osc_tick) begin
      ivl_cnt_r <= (ivl_cnt_r >= lnk.strobe_div) ? 16'h0 : ivl_cnt_r + 16'h1;
    end
  end
  assign osc_strobe = osc_tick && ivl_cnt_r >= lnk.strobe_div;
  // pin strobe: short rising edge; oscillator or pin or both
  wire strobe = osc_strobe || (lnk.strobe_src[1] && wake_rise);
  // ----------------------------------------
  // response randomizer
  // ----------------------------------------
  logic [15:0] lfsr_r;
  logic [15:0] gap_cnt_r;
  logic resp_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lfsr_r <= `IWMC_LFSR_SEED;
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
  end
  // ----------------------------------------
  // state machine
  // ----------------------------------------
  iwmc_state_t state_r;
  logic flag_r;
  logic [31:0] sniff_cnt_r;
  logic [3:0] ook_idx_r;
  logic ook_r;
  localparam logic [15:0] OOK_PAT = `IWMC_OOK_PATTERN;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= IWMC_OFF;
      sniff_cnt_r <= 32'h0;
    end else begin
      case (state_r)
        IWMC_OFF: begin
          if (mode_ready) begin
            state_r <= base_mode_r ? IWMC_IDLE : IWMC_SLEEP;
          end
        end
        IWMC_SLEEP: begin
          if (direct_wake) begin
            state_r <= IWMC_IDLE;
          end else if (strobe) begin
            state_r <= IWMC_SNIFF;
            sniff_cnt_r <= 32'h0;
          end
        end
        IWMC_SNIFF: begin
          if (lnk.rx_245_msg) begin
            state_r <= IWMC_RF;
          end else if (sniff_cnt_r >= 32'(SNIFF_CYC - 1)) begin
            state_r <= IWMC_SLEEP;
          end else begin
            sniff_cnt_r <= sniff_cnt_r + 32'h1;
          end
        end
        IWMC_IDLE: begin
          if (!base_mode_r && !flag_r) begin
            state_r <= IWMC_RF;
          end else if (base_mode_r && lnk.comm_wr && (lnk.comm_wake || lnk.comm_session)) begin
            state_r <= IWMC_RF;
          end
        end
        IWMC_RF: begin
          if (base_mode_r && lnk.comm_wr && !lnk.comm_wake && !lnk.comm_session) begin
            state_r <= IWMC_IDLE;
          end else if (!base_mode_r && flag_r && !lnk.comm_session) begin
            state_r <= IWMC_IDLE;
          end
        end
        default: state_r <= IWMC_OFF;
      endcase
    end
  end
  // post-wake behaviour flag
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      flag_r <= 1'b1;
    end else if (state_r == IWMC_SLEEP && direct_wake) begin
      flag_r <= 1'b1;
    end else if (state_r == IWMC_SNIFF && lnk.rx_245_msg) begin
      flag_r <= 1'b0;
    end else if (lnk.flag_wr) begin
      flag_r <= lnk.flag_val;
    end
  end
  // response pacing
  wire resp_active = state_r == IWMC_RF && !base_mode_r && !lnk.comm_session;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gap_cnt_r <= 16'h0;
      resp_r <= 1'b0;
    end else if (!resp_active) begin
      gap_cnt_r <= 16'h0;
      resp_r <= 1'b0;
    end else if (gap_cnt_r == 16'h0) begin
      gap_cnt_r <= {4'h1, lfsr_r[11:0]};
      resp_r <= 1'b1;
    end else begin
      gap_cnt_r <= gap_cnt_r - 16'h1;
      resp_r <= 1'b0;
    end
  end
  // base on-off keyed pattern
  wire ook_active = state_r == IWMC_RF && base_mode_r && !lnk.comm_session;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ook_idx_r <= 4'h0;
      ook_r <= 1'b0;
    end else if (!ook_active) begin
      ook_idx_r <= 4'h0;
      ook_r <= 1'b0;
    end else begin
      ook_idx_r <= ook_idx_r + 4'h1;
      ook_r <= OOK_PAT[ook_idx_r];
    end
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign lnk.state = state_r;
  assign lnk.flag = flag_r;
  assign lnk.tx_400 = state_r == IWMC_RF;
  assign lnk.rx_400 = state_r == IWMC_RF;
  assign lnk.ook = ook_r;
  assign lnk.resp_pulse = resp_r;
  assign lnk.sniff_on = state_r == IWMC_SNIFF;
endmodule : iwmc_dev

// ---- rtl/iwmc_host.sv ----
`timescale 1ns/1ps
`include "iwmc_map.svh"
module iwmc_host
  import iwmc_pkg::*;
#(
  parameter int WAKE_MIN_CYC = `IWMC_WAKE_MIN_CYC
) (
  // system
  input wire logic clock,
  input wire logic resetn,
  // user commands
  input wire logic base_sel,
  input wire logic do_direct_wake,
  input wire logic do_respond,
  input wire logic do_base_wake,
  input wire logic do_session,
  input wire logic cca_clear,
  input wire logic emergency,
  input wire logic [1:0] strobe_src,
  input wire logic [15:0] strobe_div,
  output logic busy,
  // link
  iwmc_link_if.host lnk
);
  // ----------------------------------------
  // wake pulse timer
  // ----------------------------------------
  logic [31:0] pulse_cnt_r;
  logic pin_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pulse_cnt_r <= 32'h0;
      pin_r <= 1'b0;
    end else if (!pin_r && do_direct_wake) begin
      pin_r <= 1'b1;
      pulse_cnt_r <= 32'h0;
    end else if (pin_r) begin
      if (pulse_cnt_r > 32'(WAKE_MIN_CYC + 8)) begin
        pin_r <= 1'b0;
      end else begin
        pulse_cnt_r <= pulse_cnt_r + 32'h1;
      end
    end
  end
  // ----------------------------------------
  // command strobes and sticky wake/session bits
  // ----------------------------------------
  logic flag_wr_r;
  logic comm_wr_r;
  logic comm_wake_r;
  logic comm_sess_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      flag_wr_r <= 1'b0;
      comm_wr_r <= 1'b0;
      comm_wake_r <= 1'b0;
      comm_sess_r <= 1'b0;
    end else begin
      flag_wr_r <= do_respond && !pin_r;
      comm_wr_r <= (do_base_wake && (cca_clear || emergency)) || do_session;
      if (do_base_wake && (cca_clear || emergency)) begin
        comm_wake_r <= 1'b1;
      end
      if (do_session) begin
        comm_sess_r <= 1'b1;
      end
    end
  end
  assign lnk.implant_base_select = base_sel;
  assign lnk.wake_pin = pin_r;
  assign lnk.flag_wr = flag_wr_r;
  assign lnk.flag_val = 1'b0;
  assign lnk.comm_wr = comm_wr_r;
  assign lnk.comm_wake = comm_wake_r;
  assign lnk.comm_session = comm_sess_r;
  assign lnk.strobe_src = strobe_src;
  assign lnk.strobe_div = strobe_div;
  assign busy = pin_r;
endmodule : iwmc_host

// ---- verif/iwmc_link_monitor.sv ----
`timescale 1ns/1ps
module iwmc_link_monitor
  import iwmc_pkg::*;
#(
  parameter int SNIFF_CYC = 20
) (
  // system
  input wire logic clock,
  input wire logic resetn,
  // host side
  input wire logic implant_base_select,
  input wire logic flag_wr,
  input wire logic flag_val,
  input wire logic comm_wr,
  input wire logic comm_wake,
  input wire logic rx_245_msg,
  // device side
  input wire logic [4:0] state,
  input wire logic flag,
  input wire logic tx_400,
  input wire logic rx_400,
  input wire logic resp_pulse,
  input wire logic sniff_on
);
  localparam int SNIFF_LIM = SNIFF_CYC + 3;
  logic [13:0] gap_r;
  logic seen_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // response spacing
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gap_r <= 14'h0000;
    end else if (resp_pulse || state != IWMC_RF) begin
      gap_r <= 14'h0000;
    end else if (gap_r != 14'h3FFF) begin
      gap_r <= gap_r + 14'h0001;
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      seen_r <= 1'b0;
    end else begin
      seen_r <= (state == IWMC_RF) && (seen_r || resp_pulse);
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_power_up_mode: assert property (state == IWMC_OFF ##1 state != IWMC_OFF
    |-> state == (implant_base_select ? IWMC_IDLE : IWMC_SLEEP)) else $error("wrong power-up state");
  a_radio_on_rf: assert property (tx_400 == (state == IWMC_RF) && rx_400 == (state == IWMC_RF))
    else $error("radio enables differ from rf state");
  a_sniff_out: assert property (sniff_on == (state == IWMC_SNIFF)) else $error("sniff_on wrong");
  a_flag_respond: assert property (flag_wr && !flag_val && state == IWMC_IDLE && !implant_base_select
    |-> ##2 state == IWMC_RF) else $error("flag clear did not start responses");
  a_base_wake_rf: assert property (comm_wr && comm_wake && state == IWMC_IDLE && implant_base_select
    |=> state == IWMC_RF) else $error("base wake did not enter rf");
  a_sniff_wake: assert property (state == IWMC_SNIFF && rx_245_msg |=> state == IWMC_RF ##[0:1] !flag)
    else $error("2.45 wake not taken");
  a_sniff_bounded: assert property ($rose(sniff_on) |-> ##[1:SNIFF_LIM] !sniff_on)
    else $error("sniff too long");
  a_resp_min_gap: assert property (resp_pulse && seen_r |-> gap_r >= 14'h0FFF)
    else $error("responses too close");
  a_resp_max_gap: assert property (state == IWMC_RF && !implant_base_select && !flag |-> gap_r <= 14'h2000)
    else $error("response overdue");
  a_wake_flag_one: assert property (state == IWMC_SLEEP ##1 state == IWMC_IDLE |-> ##1 flag)
    else $error("flag not one after wake");
  a_idle_holds: assert property (state == IWMC_IDLE && flag && !flag_wr && !comm_wr |=> state == IWMC_IDLE)
    else $error("idle left without cause");
  c_resp_twice: cover property (resp_pulse && seen_r);
  c_sniff_wake: cover property (state == IWMC_SNIFF && rx_245_msg);
  c_base_wake: cover property (comm_wr && comm_wake);
endmodule : iwmc_link_monitor

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`include "iwmc_map.svh"
module testbench
  import iwmc_pkg::*;
;
  localparam int WMIN = 20;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic base_sel = 1'b0;
  logic do_direct_wake = 1'b0;
  logic do_respond = 1'b0;
  logic do_base_wake = 1'b0;
  logic do_session = 1'b0;
  logic cca_clear = 1'b0;
  logic emergency = 1'b0;
  logic [1:0] strobe_src = 2'h0;
  logic [15:0] strobe_div = 16'h0000;
  logic busy;
  logic [31:0] seq;
  logic [31:0] dbl;
  logic hit;
  int n;
  int miscompares = 0;
  int n_compared = 0;
  iwmc_link_if lnk();
  iwmc_link_if lnk2();
  // ----------------------------------------
  // both ends, plus a second device with a bench-driven pin
  // ----------------------------------------
  iwmc_host #(.WAKE_MIN_CYC(WMIN)) iwmc_host_i (.clock(clock), .resetn(resetn), .base_sel(base_sel),
    .do_direct_wake(do_direct_wake), .do_respond(do_respond), .do_base_wake(do_base_wake),
    .do_session(do_session), .cca_clear(cca_clear), .emergency(emergency), .strobe_src(strobe_src),
    .strobe_div(strobe_div), .busy(busy), .lnk(lnk));
  iwmc_dev #(.WAKE_MIN_CYC(WMIN), .SNIFF_CYC(20), .STROSC_DIV(4)) iwmc_dev_i (.clock(clock), .resetn(resetn),
    .lnk(lnk));
  iwmc_dev #(.WAKE_MIN_CYC(WMIN), .SNIFF_CYC(20), .STROSC_DIV(4)) iwmc_dev_i2 (.clock(clock), .resetn(resetn),
    .lnk(lnk2));
  iwmc_link_monitor #(.SNIFF_CYC(20)) iwmc_link_monitor_i (.clock(clock), .resetn(resetn),
    .implant_base_select(lnk.implant_base_select), .flag_wr(lnk.flag_wr), .flag_val(lnk.flag_val),
    .comm_wr(lnk.comm_wr), .comm_wake(lnk.comm_wake), .rx_245_msg(lnk.rx_245_msg), .state(lnk.state),
    .flag(lnk.flag), .tx_400(lnk.tx_400), .rx_400(lnk.rx_400), .resp_pulse(lnk.resp_pulse),
    .sniff_on(lnk.sniff_on));
  assign lnk2.implant_base_select = lnk.implant_base_select;
  assign lnk2.flag_wr = lnk.flag_wr;
  assign lnk2.flag_val = lnk.flag_val;
  assign lnk2.comm_wr = lnk.comm_wr;
  assign lnk2.comm_wake = lnk.comm_wake;
  assign lnk2.comm_session = lnk.comm_session;
  assign lnk2.rx_245_msg = lnk.rx_245_msg;
  assign lnk2.strobe_div = lnk.strobe_div;
  always #2.5 clock = ~clock;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk_b(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk_b
  task automatic wait_st(input logic [4:0] exp, input int lim);
    int k;
    k = 0;
    while (lnk.state !== exp && k < lim) begin
      @(negedge clock);
      k++;
    end
    n_compared++;
    if (lnk.state !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: state %h expected %h", $time, lnk.state, exp);
    end
  endtask : wait_st
  task automatic wait_resp;
    int k;
    k = 0;
    while (lnk.resp_pulse !== 1'b1 && k < 8300) begin
      @(negedge clock);
      k++;
    end
    chk_b(lnk.resp_pulse, 1'b1);
    @(negedge clock);
  endtask : wait_resp
  task automatic do_reset(input logic b, input logic [1:0] src);
    @(negedge clock);
    resetn = 1'b0;
    base_sel = b;
    strobe_src = src;
    repeat (8) @(negedge clock);
    resetn = 1'b1;
  endtask : do_reset
  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    lnk.rx_245_msg = 1'b0;
    lnk2.wake_pin = 1'b0;
    lnk2.strobe_src = 2'h0;
    do_reset(1'b0, 2'h0);
    wait_st(IWMC_SLEEP, 10);
    lnk2.wake_pin = 1'b1;
    repeat (5) @(negedge clock);
    lnk2.wake_pin = 1'b0;
    repeat (40) @(negedge clock);
    chk_b(lnk2.state === IWMC_SLEEP, 1'b1);
    lnk2.strobe_src = 2'h2;
    lnk2.wake_pin = 1'b1;
    for (n = 0; n < 20 && lnk2.sniff_on !== 1'b1; n++) @(negedge clock);
    chk_b(lnk2.sniff_on, 1'b1);
    lnk2.wake_pin = 1'b0;
    wait_st(IWMC_SLEEP, 1);
    chk_b(lnk.flag, 1'b1);
    do_direct_wake = 1'b1;
    @(negedge clock);
    do_direct_wake = 1'b0;
    chk_b(busy, 1'b1);
    wait_st(IWMC_IDLE, WMIN * 4);
    chk_b(lnk.flag, 1'b1);
    repeat (30) @(negedge clock);
    wait_st(IWMC_IDLE, 0);
    do_respond = 1'b1;
    @(negedge clock);
    do_respond = 1'b0;
    wait_st(IWMC_RF, 20);
    wait_resp();
    wait_resp();
    $display("test direct wake done");
    do_reset(1'b0, 2'h1);
    wait_st(IWMC_SNIFF, 100);
    chk_b(lnk.sniff_on, 1'b1);
    lnk.rx_245_msg = 1'b1;
    wait_st(IWMC_RF, 5);
    lnk.rx_245_msg = 1'b0;
    @(negedge clock);
    chk_b(lnk.flag, 1'b0);
    chk_b(lnk.rx_400, 1'b1);
    wait_resp();
    $display("test strobed wake done");
    do_reset(1'b1, 2'h0);
    wait_st(IWMC_IDLE, 10);
    cca_clear = 1'b1;
    do_base_wake = 1'b1;
    @(negedge clock);
    do_base_wake = 1'b0;
    wait_st(IWMC_RF, 20);
    chk_b(lnk.tx_400, 1'b1);
    @(negedge clock);
    for (n = 0; n < 32; n++) begin
      seq[n] = lnk.ook;
      @(negedge clock);
    end
    hit = 1'b0;
    for (n = 0; n < 16; n++) begin
      dbl = {`IWMC_OOK_PATTERN, `IWMC_OOK_PATTERN} >> n;
      if (dbl[15:0] === seq[15:0]) hit = 1'b1;
    end
    chk_b(hit, 1'b1);
    chk_b(seq[31:16] === seq[15:0], 1'b1);
    do_session = 1'b1;
    @(negedge clock);
    do_session = 1'b0;
    repeat (5) @(negedge clock);
    wait_st(IWMC_RF, 0);
    chk_b(lnk.ook, 1'b0);
    $display("test base wake done");
    close_out();
  end
  // longest run is under 9000 cycles
  initial begin
    #400000;
    miscompares++;
    close_out();
  end
endmodule : testbench
